/* hdl/uef_endpoint_access.sv */
// Firmware side of the low-speed serial engine: address update, endpoint buffer command, data ports
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
`include "uef_consts.svh"

module uef_endpoint_access #(
    parameter int ACCESS_CYCLES = `UEF_ACCESS_CYCLES
) (
    input wire logic clock, // System clock, 100 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction, 1 = write
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic pready, // APB ready
    output logic [31:0] prdata, // APB read data
    output logic pslverr, // APB error on unmapped address
    input wire logic usbBusReset, // USB bus reset seen, level
    input wire logic hostInDone, // Host completed an IN read, pulse
    input wire logic ep0Error, // Error while accessing endpoint 0 buffer, pulse
    input wire logic setupSeen, // SETUP packet landed in a buffer, pulse
    input wire logic zeroLenSeen, // Empty packet received from host, pulse
    input wire logic ep0Access, // Any host token on endpoint 0, including NAK, pulse
    input wire logic ep0DataMoved, // Endpoint 0 data really sent or received, pulse
    input wire logic [2:0] canRead, // Per endpoint: a byte waits to be read
    input wire logic [2:0] canWrite, // Per endpoint: room for a byte
    input wire logic [7:0] rxByte, // Current byte of the selected buffer
    output logic [6:0] deviceAddress, // Active device address
    output logic usbInterrupt, // Interrupt to the core, pulse
    output logic popStrobe, // Byte taken from buffer portEp, pulse
    output logic pushStrobe, // txByte written to buffer portEp, pulse
    output logic [1:0] portEp, // Endpoint of the last data port access
    output logic [7:0] txByte, // Byte written by firmware
    output logic flushStrobe, // Empty buffer flushEp, pulse
    output logic [1:0] flushEp // Endpoint to be emptied
);
    localparam int TW = $clog2(ACCESS_CYCLES + 1);

    function automatic uef_pkg::uef_reg_t decodeReg(input logic [11:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        if (addr[1:0] != 2'h0 || addr[11:10] != 2'h0) begin
            return uef_pkg::UEF_REG_NONE;
        end
        case (idx)
            `UEF_IDX_STATUS_CONTROL: return uef_pkg::UEF_REG_STATUS_CONTROL;
            `UEF_IDX_BUFFER_COMMAND: return uef_pkg::UEF_REG_BUFFER_COMMAND;
            `UEF_IDX_EP0_DATA, `UEF_IDX_EP1_DATA,
            `UEF_IDX_EP2_DATA: return uef_pkg::UEF_REG_DATA_PORT;
            `UEF_IDX_DEVICE_ADDRESS: return uef_pkg::UEF_REG_DEVICE_ADDRESS;
            default: return uef_pkg::UEF_REG_NONE;
        endcase
    endfunction

    // Registers
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic addrDefer_q, ep0Err_q, nakMask_q;
    logic req_q, dir_q, setup_q, zeroLen_q, ready_q;
    uef_pkg::uef_ep_t sel_q;
    logic [6:0] devAddr_q, pendAddr_q;
    logic pendValid_q;
    logic [TW-1:0] timer_q;
    logic irq_q, pop_q, push_q, flush_q;
    uef_pkg::uef_ep_t portEp_q, flushEp_q;
    logic [7:0] txByte_q;

    // Bus decode
    wire uef_pkg::uef_reg_t regSel = decodeReg(paddr);
    wire access = psel && penable;
    wire done = access && pready_q;
    wire wrLane = pwrite && pstrb[0];
    wire wrDone = done && wrLane;
    wire rdDone = done && !pwrite;
    wire wrSc = wrDone && regSel == uef_pkg::UEF_REG_STATUS_CONTROL;
    wire wrBc = wrDone && regSel == uef_pkg::UEF_REG_BUFFER_COMMAND;
    wire wrAddr = wrDone && regSel == uef_pkg::UEF_REG_DEVICE_ADDRESS;
    wire isPort = regSel == uef_pkg::UEF_REG_DATA_PORT;
    wire uef_pkg::uef_ep_t portSel = uef_pkg::uef_ep_t'(paddr[3:2] - 2'h0);
    wire portRd = rdDone && isPort;
    wire portWr = wrDone && isPort;
    wire [7:0] wd = pwdata[7:0];

    // Address update
    wire deferLoad = addrDefer_q && pendValid_q && hostInDone;
    wire [6:0] devAddr_d = (wrAddr && !addrDefer_q) ? wd[6:0] :
        deferLoad ? pendAddr_q : devAddr_q;
    wire addrDefer_d = wrSc ? wd[`UEF_SC_ADDR_DEFER] :
        deferLoad ? 1'b0 : addrDefer_q;
    wire pendValid_d = (wrAddr && addrDefer_q) || (pendValid_q && !deferLoad);
    wire [6:0] pendAddr_d = (wrAddr && addrDefer_q) ? wd[6:0] : pendAddr_q;

    // Hardware set wins over a firmware clear
    wire ep0Err_d = ep0Error || (ep0Err_q && !(wrSc && !wd[`UEF_SC_EP0_ERROR]));
    wire nakMask_d = wrSc ? wd[`UEF_SC_NAK_MASK] : nakMask_q;
    wire irq_d = nakMask_q ? ep0DataMoved : ep0Access;

    // Buffer command; bus reset clears everything, including pending flags
    wire reqRise = wrBc && wd[`UEF_BC_REQUEST] && !req_q;
    wire req_d = usbBusReset ? 1'b0 : wrBc ? wd[`UEF_BC_REQUEST] : req_q;
    wire dir_d = usbBusReset ? 1'b0 : wrBc ? wd[`UEF_BC_DIRECTION] : dir_q;
    wire uef_pkg::uef_ep_t sel_d = usbBusReset ? 2'h0 :
        wrBc ? wd[`UEF_BC_SELECT_HI:`UEF_BC_SELECT_LO] : sel_q;
    wire setup_d = !usbBusReset && (setupSeen ||
        (setup_q && !(wrBc && !wd[`UEF_BC_SETUP])));
    wire zeroLen_d = !usbBusReset && (zeroLenSeen ||
        (zeroLen_q && !(wrBc && !wd[`UEF_BC_ZERO_LEN])));
    wire flush_d = wrBc && wd[`UEF_BC_FLUSH] && !usbBusReset;

    // Access timer restarts on each request and each data port access to the selected endpoint
    wire selPortAccess = (portRd || portWr) && portSel == sel_q;
    wire timerStart = reqRise || selPortAccess;
    wire [TW-1:0] timer_d = timerStart ? TW'(ACCESS_CYCLES) :
        (timer_q != '0) ? timer_q - TW'(1) : timer_q;
    wire selValid = sel_q != 2'h3;
    wire bufOk = dir_q ? canWrite[sel_q] : canRead[sel_q];
    // Ready only for the selected endpoint under an active request; a command write
    // drops it for a cycle so it never outlives a request or select that just changed
    wire ready_d = !usbBusReset && !timerStart && !wrBc && req_q && selValid &&
        timer_q == '0 && bufOk;

    // Read mux
    wire [7:0] scRead = {nakMask_q, 5'h00, ep0Err_q, addrDefer_q};
    wire [7:0] bcRead = {zeroLen_q, ready_q, setup_q, sel_q, 1'b0, dir_q, req_q};
    wire [7:0] rdByte = regSel == uef_pkg::UEF_REG_STATUS_CONTROL ? scRead :
        regSel == uef_pkg::UEF_REG_BUFFER_COMMAND ? bcRead :
        regSel == uef_pkg::UEF_REG_DEVICE_ADDRESS ? {1'b0, devAddr_q} :
        isPort ? rxByte : 8'h00;

    // One wait state: pready rises on the second cycle of the access phase
    always_ff @(posedge clock) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access && !pready_q;
            pslverr_q <= access && !pready_q && regSel == uef_pkg::UEF_REG_NONE;
            prdata_q <= (access && !pready_q && !pwrite) ? {24'h000000, rdByte} : 32'h0000_0000;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            addrDefer_q <= 1'b0;
            ep0Err_q <= 1'b0;
            nakMask_q <= 1'b0;
            devAddr_q <= `UEF_RST_DEVICE_ADDRESS;
            pendAddr_q <= `UEF_RST_DEVICE_ADDRESS;
            pendValid_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            addrDefer_q <= addrDefer_d;
            ep0Err_q <= ep0Err_d;
            nakMask_q <= nakMask_d;
            devAddr_q <= devAddr_d;
            pendAddr_q <= pendAddr_d;
            pendValid_q <= pendValid_d;
            irq_q <= irq_d;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            req_q <= 1'b0;
            dir_q <= 1'b0;
            sel_q <= 2'h0;
            setup_q <= 1'b0;
            zeroLen_q <= 1'b0;
            ready_q <= 1'b0;
            timer_q <= '0;
        end else begin
            req_q <= req_d;
            dir_q <= dir_d;
            sel_q <= sel_d;
            setup_q <= setup_d;
            zeroLen_q <= zeroLen_d;
            ready_q <= ready_d;
            timer_q <= timer_d;
        end
    end

    // Data port strobes; reserved select flushes nothing
    always_ff @(posedge clock) begin
        if (rst) begin
            pop_q <= 1'b0;
            push_q <= 1'b0;
            portEp_q <= 2'h0;
            txByte_q <= 8'h00;
            flush_q <= 1'b0;
            flushEp_q <= 2'h0;
        end else begin
            pop_q <= portRd;
            push_q <= portWr;
            portEp_q <= (portRd || portWr) ? portSel : portEp_q;
            txByte_q <= portWr ? wd : txByte_q;
            flush_q <= flush_d && wd[`UEF_BC_SELECT_HI:`UEF_BC_SELECT_LO] != 2'h3;
            flushEp_q <= flush_d ? wd[`UEF_BC_SELECT_HI:`UEF_BC_SELECT_LO] : flushEp_q;
        end
    end

    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;
    assign deviceAddress = devAddr_q;
    assign usbInterrupt = irq_q;
    assign popStrobe = pop_q;
    assign pushStrobe = push_q;
    assign portEp = portEp_q;
    assign txByte = txByte_q;
    assign flushStrobe = flush_q;
    assign flushEp = flushEp_q;

    // Helper: register targeted by the read now being answered
    uef_pkg::uef_reg_t lastReg_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            lastReg_q <= uef_pkg::UEF_REG_NONE;
        end else begin
            lastReg_q <= regSel;
        end
    end

    AST_ADDR_NOW: assert property (@(posedge clock) disable iff (rst)
        wrAddr && !addrDefer_q |=> deviceAddress == $past(pwdata[6:0]))
        else $error("immediate address write not adopted");
    AST_ADDR_HOLD: assert property (@(posedge clock) disable iff (rst)
        addrDefer_q && !hostInDone && !wrAddr |=> $stable(deviceAddress))
        else $error("deferred address changed before IN completion");
    AST_DEFER_CLR: assert property (@(posedge clock) disable iff (rst)
        addrDefer_q && pendValid_q && hostInDone && !wrSc |=>
        !addrDefer_q && deviceAddress == $past(pendAddr_q))
        else $error("deferred update did not load and clear");
    AST_ERR_SET: assert property (@(posedge clock) disable iff (rst)
        ep0Error |=> ep0Err_q ##1 ep0Err_q || $past(wrSc))
        else $error("endpoint 0 error flag lost");
    AST_UNUSED_ZERO: assert property (@(posedge clock) disable iff (rst)
        pready_q && !pwrite && lastReg_q == uef_pkg::UEF_REG_STATUS_CONTROL |->
        prdata[6:2] == 5'h00)
        else $error("unused status bits read nonzero");
    AST_IRQ_MASK: assert property (@(posedge clock) disable iff (rst)
        nakMask_q && ep0Access && !ep0DataMoved |=> !usbInterrupt)
        else $error("masked NAK raised interrupt");
    AST_IRQ_ANY: assert property (@(posedge clock) disable iff (rst)
        !nakMask_q && ep0Access |=> usbInterrupt)
        else $error("endpoint 0 access gave no interrupt");
    AST_BUS_RESET: assert property (@(posedge clock) disable iff (rst)
        usbBusReset |=> !req_q && !dir_q && sel_q == 2'h0 && !setup_q && !zeroLen_q && !ready_q)
        else $error("bus reset left command bits set");
    AST_FLUSH: assert property (@(posedge clock) disable iff (rst)
        wrBc && wd[`UEF_BC_FLUSH] && !usbBusReset && wd[4:3] != 2'h3 |=>
        flushStrobe && flushEp == $past(wd[4:3]))
        else $error("flush not issued");
    AST_READY_QUAL: assert property (@(posedge clock) disable iff (rst)
        ready_q |-> req_q && sel_q != 2'h3)
        else $error("ready without active request");
    AST_ACCESS_WAIT: assert property (@(posedge clock) disable iff (rst)
        selPortAccess |=> !ready_q [*8])
        else $error("ready returned before access time");
    AST_SETUP_SET: assert property (@(posedge clock) disable iff (rst)
        setupSeen && !usbBusReset |=> setup_q)
        else $error("setup flag not set");
    AST_ZLP_SET: assert property (@(posedge clock) disable iff (rst)
        zeroLenSeen && !usbBusReset |=> zeroLen_q)
        else $error("zero length flag not set");

    COV_READ_BYTE: cover property (@(posedge clock) disable iff (rst) ready_q && portRd);
    COV_WRITE_BYTE: cover property (@(posedge clock) disable iff (rst) ready_q && portWr);
    COV_DEFER: cover property (@(posedge clock) disable iff (rst) deferLoad);
    COV_ZLP: cover property (@(posedge clock) disable iff (rst) zeroLen_q && ready_q);
endmodule

/* pkg/uef_consts.svh */
// Register offsets, field positions, reset values and timing counts of the endpoint access block
`ifndef UEF_CONSTS_SVH
`define UEF_CONSTS_SVH

// Register indices; byte address is four times the index
`define UEF_IDX_STATUS_CONTROL 8'h45
`define UEF_IDX_BUFFER_COMMAND 8'h46
`define UEF_IDX_EP0_DATA 8'h48
`define UEF_IDX_EP1_DATA 8'h49
`define UEF_IDX_EP2_DATA 8'h4A
`define UEF_IDX_DEVICE_ADDRESS 8'h4B

// Engine status/control fields
`define UEF_SC_ADDR_DEFER 0
`define UEF_SC_EP0_ERROR 1
`define UEF_SC_NAK_MASK 7

// Buffer command fields
`define UEF_BC_REQUEST 0
`define UEF_BC_DIRECTION 1
`define UEF_BC_FLUSH 2
`define UEF_BC_SELECT_LO 3
`define UEF_BC_SELECT_HI 4
`define UEF_BC_SETUP 5
`define UEF_BC_READY 6
`define UEF_BC_ZERO_LEN 7

// Reset values
`define UEF_RST_STATUS_CONTROL 8'h00
`define UEF_RST_BUFFER_COMMAND 8'h00
`define UEF_RST_DEVICE_ADDRESS 7'h00

// Timing: data port access time
`define UEF_CLOCK_NS 10
`define UEF_ACCESS_NS 2000
`define UEF_ACCESS_CYCLES ((`UEF_ACCESS_NS + `UEF_CLOCK_NS - 1) / `UEF_CLOCK_NS)

`endif

/* pkg/uef_pkg.sv */
// Types shared by the endpoint access block
package uef_pkg;
    typedef logic [1:0] uef_ep_t;
    typedef enum logic [2:0] {
        UEF_REG_NONE,
        UEF_REG_STATUS_CONTROL,
        UEF_REG_BUFFER_COMMAND,
        UEF_REG_DATA_PORT,
        UEF_REG_DEVICE_ADDRESS
    } uef_reg_t;
endpackage

/* testbench/uef_endpoint_access_tb.sv */
// Self-checking testbench for the endpoint access block
`timescale 1ns/1ns
`include "uef_consts.svh"

module uef_endpoint_access_tb;
    localparam int ACC = 9;
    // Row layout: register index, written byte, expected readback
    localparam logic [23:0] ROWS [6] = '{24'h45FE80, 24'h457C00, 24'h465818,
                                        24'h464A0A, 24'h460000, 24'h4B7F7F};
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, usbInterrupt, popStrobe, pushStrobe, flushStrobe, err;
    logic [31:0] prdata, rdv;
    // Engine events: inDone, ep0Err, setup, zeroLen, ep0Access, dataMoved, busReset
    logic [6:0] evt = 7'h00;
    logic [2:0] canRead = 3'h0;
    logic [2:0] canWrite = 3'h0;
    logic [7:0] rxByte = 8'h00;
    logic [6:0] deviceAddress;
    logic [1:0] portEp, flushEp, lastEp, lastFlushEp;
    logic [7:0] txByte, lastTx, sel;
    int errors = 0;
    int numChecks = 0;
    int intCount = 0;
    int popCount = 0;
    int pushCount = 0;
    int flushCount = 0;
    int base, k;

    uef_endpoint_access #(.ACCESS_CYCLES(ACC)) uut (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .usbBusReset(evt[6]), .hostInDone(evt[0]), .ep0Error(evt[1]),
        .setupSeen(evt[2]), .zeroLenSeen(evt[3]), .ep0Access(evt[4]),
        .ep0DataMoved(evt[5]), .canRead(canRead), .canWrite(canWrite), .rxByte(rxByte),
        .deviceAddress(deviceAddress), .usbInterrupt(usbInterrupt),
        .popStrobe(popStrobe), .pushStrobe(pushStrobe), .portEp(portEp),
        .txByte(txByte), .flushStrobe(flushStrobe), .flushEp(flushEp)
    );

    always #5 clock = ~clock;

    // Strobes are single-cycle, so they are caught here rather than polled
    always @(posedge clock) begin
        if (usbInterrupt === 1'h1) intCount <= intCount + 1;
        if (popStrobe === 1'h1 || pushStrobe === 1'h1) lastEp <= portEp;
        if (popStrobe === 1'h1) popCount <= popCount + 1;
        if (pushStrobe === 1'h1) pushCount <= pushCount + 1;
        if (pushStrobe === 1'h1) lastTx <= txByte;
        if (flushStrobe === 1'h1) flushCount <= flushCount + 1;
        if (flushStrobe === 1'h1) lastFlushEp <= flushEp;
    end

    task end_of_test;
        $display("checks %0d errors %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task waitCyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Leading edge keeps a released psel from being raised in the same time step
    task apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
             output logic [31:0] r, output logic e);
        int n;
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'h1 && n < 50);
        r = prdata;
        e = pslverr;
        if (n >= 50) chk("pready", 32'h0, 32'h1);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'h1, idx, d, rdv, err);
    endtask

    task rd(input string nm, input logic [7:0] idx, input logic [7:0] x);
        apb(1'h0, idx, 8'h00, rdv, err);
        chk(nm, rdv, {24'h0, x});
    endtask

    task pulse(input int i);
        @(posedge clock);
        evt[i] <= 1'h1;
        @(posedge clock);
        evt[i] <= 1'h0;
    endtask

    initial begin
        repeat (5000) @(posedge clock);
        chk("watchdog", 32'h0, 32'h1);
        end_of_test;
    end

    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'h0;
        rd("statusReset", 8'h45, 8'h00);
        rd("commandReset", 8'h46, 8'h00);
        for (k = 0; k < 6; k++) begin
            wr(ROWS[k][23:16], ROWS[k][15:8]);
            rd("row", ROWS[k][23:16], ROWS[k][7:0]);
        end
        wr(8'h4B, 8'h12);
        waitCyc(2);
        chk("addrNow", {25'h0, deviceAddress}, 32'h12);
        wr(8'h45, 8'h01);
        wr(8'h4B, 8'h34);
        waitCyc(3);
        chk("addrHeld", {25'h0, deviceAddress}, 32'h12);
        pulse(0);
        waitCyc(2);
        chk("addrLoaded", {25'h0, deviceAddress}, 32'h34);
        pstrb <= 4'hE;
        wr(8'h4B, 8'h55);
        pstrb <= 4'hF;
        waitCyc(1);
        chk("laneOff", {25'h0, deviceAddress}, 32'h34);
        rd("deferClear", 8'h45, 8'h00);
        pulse(1);
        rd("errSet", 8'h45, 8'h02);
        wr(8'h45, 8'h02);
        rd("errKept", 8'h45, 8'h02);
        wr(8'h45, 8'h00);
        rd("errClear", 8'h45, 8'h00);
        base = intCount;
        pulse(4);
        pulse(5);
        waitCyc(3);
        chk("irqUnmasked", intCount - base, 32'h1);
        wr(8'h45, 8'h80);
        pulse(4);
        waitCyc(3);
        chk("irqNak", intCount - base, 32'h1);
        pulse(5);
        waitCyc(3);
        chk("irqData", intCount - base, 32'h2);
        for (k = 0; k < 3; k++) begin
            sel = 8'(k << 3);
            canRead <= 3'(1 << k);
            rxByte <= 8'(8'hA0 + k);
            wr(8'h46, sel);
            wr(8'h46, sel | 8'h01);
            rd("notYet", 8'h46, sel | 8'h01);
            waitCyc(ACC + 5);
            rd("ready", 8'h46, sel | 8'h41);
            base = popCount;
            rd("data", 8'(8'h48 + k), 8'(8'hA0 + k));
            waitCyc(2);
            chk("pop", popCount - base, 32'h1);
            chk("popEp", {30'h0, lastEp}, k);
            rd("afterPop", 8'h46, sel | 8'h01);
            waitCyc(ACC + 5);
            rd("nextReady", 8'h46, sel | 8'h41);
            rd("data2", 8'(8'h48 + k), 8'(8'hA0 + k));
            canRead <= ~3'(1 << k);
            waitCyc(ACC + 5);
            rd("otherEp", 8'h46, sel | 8'h01);
            wr(8'h46, sel | 8'h03);
            wr(8'h46, sel | 8'h02);
            rd("closed", 8'h46, sel | 8'h02);
        end
        canRead <= 3'h0;
        canWrite <= 3'h2;
        for (k = 0; k < 2; k++) begin
            wr(8'h46, 8'h0A);
            wr(8'h46, 8'h0B);
            waitCyc(ACC + 5);
            rd("wrReady", 8'h46, 8'h4B);
            base = pushCount;
            if (k == 0) begin
                wr(8'h49, 8'h5C);
                rd("wrBusy", 8'h46, 8'h0B);
                chk("pushByte", {24'h0, lastTx}, 32'h5C);
                chk("pushEp", {30'h0, lastEp}, 32'h1);
            end
            chk("pushes", pushCount - base, (k == 0) ? 32'h1 : 32'h0);
            wr(8'h46, 8'h09);
            wr(8'h46, 8'h08);
        end
        canWrite <= 3'h0;
        wr(8'h46, 8'h00);
        wr(8'h46, 8'h01);
        // Empty packet lands under the request; the 00H write would clear an older flag
        pulse(3);
        waitCyc(ACC + 5);
        rd("zeroLen", 8'h46, 8'h81);
        apb(1'h0, 8'h48, 8'h00, rdv, err);
        wr(8'h46, 8'h03);
        wr(8'h46, 8'h02);
        rd("zeroDone", 8'h46, 8'h02);
        pulse(2);
        rd("setup", 8'h46, 8'h22);
        wr(8'h46, 8'h23);
        pulse(6);
        rd("busReset", 8'h46, 8'h00);
        base = flushCount;
        wr(8'h46, 8'h14);
        waitCyc(2);
        chk("flush", flushCount - base, 32'h1);
        chk("flushEp", {30'h0, lastFlushEp}, 32'h2);
        rd("flushBit", 8'h46, 8'h10);
        wr(8'h46, 8'h1C);
        waitCyc(2);
        chk("flushRsvd", flushCount - base, 32'h1);
        apb(1'h0, 8'h47, 8'h00, rdv, err);
        chk("unmappedErr", {31'h0, err}, 32'h1);
        chk("unmappedData", rdv, 32'h0);
        end_of_test;
    end
endmodule
